// ### verilog/sizer_consts.vh
// constants for the sdram sizing and configuration controller
// assumes an includer that needs offsets, field positions and timing counts
`ifndef SIZER_CONSTS_VH
`define SIZER_CONSTS_VH

// ************************************************************
// software register offsets (byte addresses, one word each)
// ************************************************************
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_SPEED 8'h08
`define OFS_CFG0 8'h20
`define OFS_CFG_LAST 8'h3c

// control word: write-one pulses
`define CTRL_INIT_BIT 0
`define CTRL_SIZE_BIT 1

// status word fields
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ERR_BIT 2
`define STAT_STATE_LSB 4

// per-block config word: size code, enable, base in 32 mbyte units
`define CFG_SIZE_LSB 0
`define CFG_EN_BIT 4
`define CFG_BASE_LSB 8
`define CFG_RESET 32'h0000_0000

// speed word: forced timing bits
`define SPEED_WR_BIT 8
`define SPEED_DP_BIT 9
`define SPEED_RESET 32'h0000_0000

// ************************************************************
// device control register indices (on dev_addr, control space)
// ************************************************************
`define DREG_SPEED 32'h0000_0000
`define DREG_ECC 32'h0000_0001
`define DREG_SCRUB 32'h0000_0002
`define DREG_BASE0 32'h0000_0010
`define DREG_ENSZ0 32'h0000_0018

// ecc control value for pattern sizing: only the ecc enable set
`define ECC_REFINH_BIT 0
`define ECC_CBWR_BIT 1
`define ECC_EN_BIT 2
`define ECC_IRQ_LSB 3
`define ECC_MCHK_BIT 7
`define SCRUB_ZERO 64'h0000_0000_0000_0000

// device enable/size word
`define ENSZ_EN_BIT 4

// ************************************************************
// size codes and timing
// ************************************************************
`define SIZE_NONE 4'h0
`define SIZE_32M 4'h1
`define SIZE_MAX 4'h9
`define BASE_UNIT_SHIFT 25
`define REFRESH_TICKS 32'h0000_0064
`define PATTERN_HI 32'ha5c3_0000

`endif

// ### verilog/refresh_wait.v
// refresh wait: ends when the free-running counter has moved far enough
// assumes counter_value is synchronous to clk_sys and counts upward
`timescale 1ns/1ps
`include "sizer_consts.vh"

module refresh_wait
(
	// clock and reset
	input wire clk_sys,
	input wire arst_n,
	// request and answer
	input wire start,
	input wire [31:0] counter_value,
	output reg done
);

reg [31:0] mark;
reg run;
wire [31:0] moved;

// wrap-safe difference so a counter rollover does not cut the wait short
assign moved = counter_value - mark;

// capture the counter, then wait for the distance
always @(posedge clk_sys or negedge arst_n)
begin
	if (!arst_n)
	begin
		mark <= 32'h0000_0000;
		run <= 1'b0;
		done <= 1'b0;
	end
	else
	begin
		done <= 1'b0;
		if (start)
		begin
			mark <= counter_value;
			run <= 1'b1;
		end
		else if (run && moved >= `REFRESH_TICKS)
		begin
			run <= 1'b0;
			done <= 1'b1;
		end
	end
end

endmodule

// ### verilog/probe_rom.v
// probe address list for each trial size code
// assumes code is a legal nonzero size code; others give address zero only
`timescale 1ns/1ps

module probe_rom
(
	// lookup
	input wire [3:0] code,
	input wire [1:0] index,
	output reg [31:0] addr,
	output reg [1:0] last
);

// every list opens with zero, then the alias offsets of that size
always @*
begin
	addr = 32'h0000_0000;
	last = 2'h0;
	case (code)
		4'h9:
		begin
			last = 2'h2;
			if (index == 2'h1)
				addr = 32'h0000_8000;
			else if (index == 2'h2)
				addr = 32'h1000_0000;
		end
		4'h8:
		begin
			last = 2'h2;
			if (index == 2'h1)
				addr = 32'h0000_4000;
			else if (index == 2'h2)
				addr = 32'h0800_0000;
		end
		4'h7:
		begin
			last = 2'h2;
			if (index == 2'h1)
				addr = 32'h0000_8000;
			else if (index == 2'h2)
				addr = 32'h0800_0000;
		end
		4'h6:
		begin
			last = 2'h1;
			if (index == 2'h1)
				addr = 32'h0400_0000;
		end
		4'h5, 4'h4:
		begin
			last = 2'h1;
			if (index == 2'h1)
				addr = 32'h0000_4000;
		end
		4'h3, 4'h2:
		begin
			last = 2'h1;
			if (index == 2'h1)
				addr = 32'h0000_2000;
		end
		4'h1:
		begin
			last = 2'h1;
			if (index == 2'h1)
				addr = 32'h0000_1000;
		end
		default:
		begin
			last = 2'h0;
		end
	endcase
end

endmodule

// ### verilog/sdram_sizer.v
// host-side controller that configures and sizes an eight-block sdram controller
// assumes an ahb-lite master for software, and a device port that acknowledges each access
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "sizer_consts.vh"

module sdram_sizer
(
	// clock and reset
	input wire clk_sys,
	input wire arst_n,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	// free-running counter of the device
	input wire [31:0] counter_value,
	// device access port
	output reg dev_req,
	output reg dev_write,
	output reg dev_mem,
	output reg [31:0] dev_addr,
	output reg [63:0] dev_wdata,
	input wire [63:0] dev_rdata,
	input wire dev_ack
);

// ************************************************************
// states
// ************************************************************
localparam ST_IDLE = 4'h0;
localparam ST_WAIT = 4'h1;
localparam ST_SPEED = 4'h2;
localparam ST_BASE = 4'h3;
localparam ST_ENSZ = 4'h4;
localparam ST_ECC = 4'h5;
localparam ST_SCRUB = 4'h6;
localparam ST_TBASE = 4'h7;
localparam ST_TENSZ = 4'h8;
localparam ST_PWR = 4'h9;
localparam ST_PRD = 4'ha;
localparam ST_JUDGE = 4'hb;
localparam ST_OFF = 4'hc;

reg [3:0] state;
reg [3:0] ret_state;
reg busy;
reg done_flag;
reg err_flag;
reg [2:0] blk;
reg [2:0] j;
reg [1:0] k;
reg [3:0] code;
reg miss;
reg ref_start;
reg [31:0] speed;
reg [31:0] cfg [0:7];

// ahb address phase capture
reg ph_wr;
reg ph_valid;
reg [7:0] ph_addr;

wire ref_done;
wire [31:0] probe_addr;
wire [1:0] probe_last;
wire take;
wire ph_cfg;
wire [2:0] ph_idx;
wire [63:0] pattern;
wire op_done;
wire cfg_bad;

// ************************************************************
// helpers
// ************************************************************

// log2 of block size in 32 mbyte units for each code
function [2:0] size_log;
	input [3:0] c;
	begin
		case (c)
			4'h1: size_log = 3'h0;
			4'h2, 4'h3: size_log = 3'h1;
			4'h4, 4'h5, 4'h6: size_log = 3'h2;
			4'h7, 4'h8: size_log = 3'h3;
			default: size_log = 3'h4;
		endcase
	end
endfunction

// a config is refused if misaligned, oversized code, or enabled with no size
function cfg_wrong;
	input [31:0] w;
	reg [7:0] base_u;
	reg [7:0] mask;
	begin
		base_u = w[`CFG_BASE_LSB +: 8];
		mask = (8'h01 << size_log(w[`CFG_SIZE_LSB +: 4])) - 8'h01;
		cfg_wrong = ((base_u & mask) != 8'h00)
			|| (w[`CFG_SIZE_LSB +: 4] > `SIZE_MAX)
			|| (w[`CFG_EN_BIT] && w[`CFG_SIZE_LSB +: 4] == `SIZE_NONE);
	end
endfunction

// check every block config in one loop
genvar g;
wire [7:0] bad_vec;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : chk
		assign bad_vec[g] = cfg_wrong(cfg[g]);
	end
endgenerate
assign cfg_bad = |bad_vec;

// unique pattern per address and block so aliasing shows up as mismatch
assign pattern = {`PATTERN_HI | {21'h000000, blk, code, k, 2'h0}, probe_addr};

assign op_done = dev_req && dev_ack;
assign take = hsel && hready && htrans[1];
assign ph_cfg = (ph_addr >= `OFS_CFG0) && (ph_addr <= `OFS_CFG_LAST);
assign ph_idx = ph_addr[4:2];

// ************************************************************
// sub-blocks
// ************************************************************
refresh_wait u_wait
(
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.start(ref_start),
	.counter_value(counter_value),
	.done(ref_done)
);

probe_rom u_probe
(
	.code(code),
	.index(k),
	.addr(probe_addr),
	.last(probe_last)
);

// ************************************************************
// device access for the present state
// ************************************************************
reg next_write;
reg next_mem;
reg [31:0] next_addr;
reg [63:0] next_wdata;

// one access per op state; fields are loaded when the request rises
always @*
begin
	next_write = 1'b1;
	next_mem = 1'b0;
	next_addr = 32'h0000_0000;
	next_wdata = 64'h0000_0000_0000_0000;
	case (state)
		ST_SPEED:
		begin
			next_addr = `DREG_SPEED;
			next_wdata = {32'h0000_0000, speed};
			next_wdata[`SPEED_WR_BIT] = 1'b1;
			next_wdata[`SPEED_DP_BIT] = 1'b1;
		end
		ST_BASE:
		begin
			next_addr = `DREG_BASE0 + {29'h0000_0000, j};
			next_wdata = {32'h0000_0000, cfg[j][`CFG_BASE_LSB +: 7], `BASE_UNIT_SHIFT'h0};
		end
		ST_ENSZ:
		begin
			next_addr = `DREG_ENSZ0 + {29'h0000_0000, j};
			next_wdata = {59'h0, cfg[j][`CFG_EN_BIT], cfg[j][`CFG_SIZE_LSB +: 4]};
		end
		ST_ECC:
		begin
			// inhibit, check-bit write, irqs and machine check all zero
			next_addr = `DREG_ECC;
			next_wdata = 64'h0000_0000_0000_0000;
			next_wdata[`ECC_EN_BIT] = 1'b1;
		end
		ST_SCRUB:
		begin
			next_addr = `DREG_SCRUB;
			next_wdata = `SCRUB_ZERO;
		end
		ST_TBASE:
		begin
			next_addr = `DREG_BASE0 + {29'h0000_0000, blk};
			next_wdata = 64'h0000_0000_0000_0000;
		end
		ST_TENSZ:
		begin
			next_addr = `DREG_ENSZ0 + {29'h0000_0000, j};
			if (j == blk)
				next_wdata = {59'h0, 1'b1, code};
		end
		ST_PWR:
		begin
			next_mem = 1'b1;
			next_addr = probe_addr;
			next_wdata = pattern;
		end
		ST_PRD:
		begin
			next_write = 1'b0;
			next_mem = 1'b1;
			next_addr = probe_addr;
		end
		ST_OFF:
		begin
			next_addr = `DREG_ENSZ0 + {29'h0000_0000, j};
		end
		default:
		begin
			next_write = 1'b1;
		end
	endcase
end

// ************************************************************
// sequencer
// ************************************************************
integer n;

// ahb capture, software registers and the sizing and init engine
always @(posedge clk_sys or negedge arst_n)
begin
	if (!arst_n)
	begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		hrdata <= 32'h0000_0000;
		ph_wr <= 1'b0;
		ph_valid <= 1'b0;
		ph_addr <= 8'h00;
		state <= ST_IDLE;
		ret_state <= ST_IDLE;
		busy <= 1'b0;
		done_flag <= 1'b0;
		err_flag <= 1'b0;
		blk <= 3'h0;
		j <= 3'h0;
		k <= 2'h0;
		code <= `SIZE_MAX;
		miss <= 1'b0;
		ref_start <= 1'b0;
		speed <= `SPEED_RESET;
		dev_req <= 1'b0;
		dev_write <= 1'b0;
		dev_mem <= 1'b0;
		dev_addr <= 32'h0000_0000;
		dev_wdata <= 64'h0000_0000_0000_0000;
		for (n = 0; n < 8; n = n + 1)
			cfg[n] <= `CFG_RESET;
	end
	else
	begin
		ref_start <= 1'b0;
		ph_valid <= take;
		ph_wr <= take && hwrite;
		if (take)
			ph_addr <= haddr[7:0];
		// read data registered in the address phase, stands in the data phase
		if (take && !hwrite)
		begin
			case (haddr[7:0])
				`OFS_STATUS: hrdata <= {24'h0, state, 1'b0, err_flag, done_flag, busy};
				`OFS_SPEED: hrdata <= speed;
				default: hrdata <= (haddr[7:0] >= `OFS_CFG0 && haddr[7:0] <= `OFS_CFG_LAST)
					? cfg[haddr[4:2]] : 32'h0000_0000;
			endcase
		end

		// software writes; engine busy means config and start are left alone
		if (ph_valid && ph_wr && !busy)
		begin
			if (ph_addr == `OFS_SPEED)
				speed <= hwdata;
			else if (ph_cfg)
				cfg[ph_idx] <= hwdata;
			else if (ph_addr == `OFS_CTRL && hwdata[`CTRL_INIT_BIT])
			begin
				done_flag <= 1'b0;
				err_flag <= cfg_bad;
				if (!cfg_bad)
				begin
					busy <= 1'b1;
					ref_start <= 1'b1;
					state <= ST_WAIT;
					ret_state <= ST_SPEED;
				end
			end
			else if (ph_addr == `OFS_CTRL && hwdata[`CTRL_SIZE_BIT])
			begin
				done_flag <= 1'b0;
				err_flag <= 1'b0;
				busy <= 1'b1;
				blk <= 3'h0;
				// controls are touched only after a refresh has had time to pass
				ref_start <= 1'b1;
				state <= ST_WAIT;
				ret_state <= ST_ECC;
			end
		end

		// device access handshake: raise with fields, drop on acknowledge
		if (state != ST_IDLE && state != ST_WAIT && state != ST_JUDGE && !dev_req)
		begin
			dev_req <= 1'b1;
			dev_write <= next_write;
			dev_mem <= next_mem;
			dev_addr <= next_addr;
			dev_wdata <= next_wdata;
		end
		if (op_done)
			dev_req <= 1'b0;

		case (state)
			ST_IDLE:
			begin
				j <= 3'h0;
			end
			ST_WAIT:
			begin
				if (ref_done)
				begin
					state <= ret_state;
					if (ret_state == ST_IDLE)
					begin
						busy <= 1'b0;
						done_flag <= 1'b1;
					end
				end
			end
			ST_SPEED:
			begin
				if (op_done)
					state <= ST_BASE;
			end
			ST_BASE:
			begin
				if (op_done)
				begin
					j <= j + 3'h1;
					if (j == 3'h7)
						state <= ST_ENSZ;
				end
			end
			ST_ENSZ:
			begin
				if (op_done)
				begin
					j <= j + 3'h1;
					if (j == 3'h7)
					begin
						ref_start <= 1'b1;
						state <= ST_WAIT;
						ret_state <= ST_IDLE;
					end
				end
			end
			ST_ECC:
			begin
				if (op_done)
					state <= ST_SCRUB;
			end
			ST_SCRUB:
			begin
				if (op_done)
					state <= ST_TBASE;
			end
			ST_TBASE:
			begin
				if (op_done)
				begin
					code <= `SIZE_MAX;
					j <= 3'h0;
					state <= ST_TENSZ;
				end
			end
			ST_TENSZ:
			begin
				if (op_done)
				begin
					j <= j + 3'h1;
					if (j == 3'h7)
					begin
						k <= 2'h0;
						miss <= 1'b0;
						ref_start <= 1'b1;
						state <= ST_WAIT;
						ret_state <= ST_PWR;
					end
				end
			end
			ST_PWR:
			begin
				if (op_done)
				begin
					k <= k + 2'h1;
					if (k == probe_last)
					begin
						k <= 2'h0;
						state <= ST_PRD;
					end
				end
			end
			ST_PRD:
			begin
				if (op_done)
				begin
					if (dev_rdata != pattern)
						miss <= 1'b1;
					k <= k + 2'h1;
					if (k == probe_last)
						state <= ST_JUDGE;
				end
			end
			ST_JUDGE:
			begin
				// code 5 is tried before 4 and 3 before 2, so a pair resolves upward
				if (!miss || code == `SIZE_32M)
				begin
					cfg[blk][`CFG_SIZE_LSB +: 4] <= miss ? `SIZE_NONE : code;
					cfg[blk][`CFG_EN_BIT] <= !miss;
					cfg[blk][`CFG_BASE_LSB +: 8] <= 8'h00;
					j <= 3'h0;
					if (blk == 3'h7)
						state <= ST_OFF;
					else
					begin
						blk <= blk + 3'h1;
						state <= ST_TBASE;
					end
				end
				else
				begin
					code <= code - 4'h1;
					j <= 3'h0;
					state <= ST_TENSZ;
				end
			end
			ST_OFF:
			begin
				if (op_done)
				begin
					j <= j + 3'h1;
					if (j == 3'h7)
					begin
						ref_start <= 1'b1;
						state <= ST_WAIT;
						ret_state <= ST_IDLE;
					end
				end
			end
			default:
			begin
				state <= ST_IDLE;
				busy <= 1'b0;
			end
		endcase
	end
end

endmodule

// ### tb/sdram_sizer_properties.sv
// checker on the sdram sizer's bus and device ports
// assumes sizer_consts.vh is on the include path
`timescale 1ns/1ps
`include "sizer_consts.vh"
module sdram_sizer_props
(
	// clock and reset
	input wire clk_sys,
	input wire arst_n,
	// ahb address phase
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	// device port
	input wire [31:0] counter_value,
	input wire dev_req,
	input wire dev_write,
	input wire dev_mem,
	input wire [31:0] dev_addr,
	input wire [63:0] dev_wdata,
	input wire dev_ack
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	reg [31:0] start_cnt;
	reg [31:0] ensz_cnt;
	wire ctl_wr = dev_req & dev_ack & dev_write & ~dev_mem;
	wire spd_wr = ctl_wr & (dev_addr == `DREG_SPEED);
	// counter stamps: start order taken, last enable/size write acknowledged
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			start_cnt <= 32'h0;
			ensz_cnt <= 32'h0;
		end
		else
		begin
			if (hsel & hready & htrans[1] & hwrite & (haddr[7:0] == `OFS_CTRL))
				start_cnt <= counter_value;
			if (ctl_wr & (dev_addr[31:3] == 29'h3))
				ensz_cnt <= counter_value;
		end
	end
	// ************
	// properties
	// ************
	a_req_holds: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_addr) && $stable(dev_wdata))
		else $error("device request changed before its ack");
	a_req_drops: assert property (dev_req && dev_ack |=> !dev_req)
		else $error("device request stayed up after its ack");
	a_speed_forced: assert property (spd_wr |-> dev_wdata[9:8] == 2'b11)
		else $error("speed written without both timing bits set");
	a_speed_waits: assert property (spd_wr |-> counter_value - start_cnt >= 32'd100)
		else $error("speed written before a refresh could pass");
	a_ecc_waits: assert property (ctl_wr && dev_addr == `DREG_ECC |-> counter_value - start_cnt >= 32'd100)
		else $error("ecc control written before a refresh could pass");
	a_ecc_sizing: assert property (ctl_wr && dev_addr == `DREG_ECC |-> dev_wdata[7:0] == 8'h04)
		else $error("ecc control not set for sizing");
	a_inhibit_clear: assert property (dev_req && dev_write && !dev_mem && dev_addr == `DREG_ECC |-> !dev_wdata[0])
		else $error("refresh inhibit requested");
	a_scrub_zero: assert property (ctl_wr && dev_addr == `DREG_SCRUB |-> dev_wdata == 64'h0)
		else $error("scrub frequency not zero");
	a_base_aligned: assert property (ctl_wr && dev_addr[31:3] == 29'h2 |-> dev_wdata[24:0] == 25'h0)
		else $error("base not on a 32 mbyte boundary");
	a_mem_waits: assert property ($rose(dev_req) && dev_mem |-> counter_value - ensz_cnt >= 32'd100)
		else $error("memory touched too soon after enable/size write");
	a_probe_list: assert property (dev_req && dev_mem |-> dev_addr inside {32'h0, 32'h1000, 32'h2000, 32'h4000,
		32'h8000, 32'h0400_0000, 32'h0800_0000, 32'h1000_0000})
		else $error("memory access off the probe lists");
	a_pattern_tag: assert property (dev_req && dev_mem && dev_write |-> dev_wdata[31:0] == dev_addr)
		else $error("probe pattern does not carry its address");
	c_speed: cover property (spd_wr);
	c_mem_read: cover property (dev_req && dev_ack && dev_mem && !dev_write);
	c_slow_ack: cover property (dev_req && !dev_ack ##1 dev_req && !dev_ack);
endmodule
bind sdram_sizer sdram_sizer_props sdram_sizer_props_inst (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite,
	.hready, .counter_value, .dev_req, .dev_write, .dev_mem, .dev_addr, .dev_wdata, .dev_ack);

// ### tb/sdram_block_model.sv
// behavioural model of eight sdram blocks, their control registers and counter
// assumes one request at a time, held by the sizer until acknowledged
`timescale 1ns/1ps
`include "sizer_consts.vh"
module sdram_block_model
(
	// clock and reset
	input wire clk_sys,
	input wire arst_n,
	// answer delay in cycles
	input wire [3:0] lat,
	// device port
	input wire dev_req,
	input wire dev_write,
	input wire dev_mem,
	input wire [31:0] dev_addr,
	input wire [63:0] dev_wdata,
	output reg [63:0] dev_rdata,
	output reg dev_ack,
	output reg [31:0] counter_value
);
	reg [63:0] speed, ecc, scrub;
	reg [63:0] base [0:7];
	reg [63:0] ensz [0:7];
	reg [3:0] real_code [0:7];
	reg [63:0] mem [0:63]; // one 64-bit word of eight bytes per location
	reg [31:0] ensz_cnt, ea;
	reg [3:0] wcnt;
	reg [2:0] blk, slot;
	integer i;
	// installed blocks; 2 and 6 are empty
	initial real_code = '{4'h9, 4'h5, 4'h0, 4'h1, 4'h3, 4'h7, 4'h0, 4'h8};
	// a block programmed above its real size folds every probe onto zero
	always @*
	begin
		blk = 3'h0;
		for (i = 0; i < 8; i = i + 1)
			if (ensz[i][`ENSZ_EN_BIT])
				blk = i[2:0];
		ea = (ensz[blk][3:0] > real_code[blk]) ? 32'h0 : dev_addr;
		// only probe addresses are stored, so each gets a fixed slot per block
		case (ea)
			32'h0000_1000: slot = 3'h1;
			32'h0000_2000: slot = 3'h2;
			32'h0000_4000: slot = 3'h3;
			32'h0000_8000: slot = 3'h4;
			32'h0400_0000: slot = 3'h5;
			32'h0800_0000: slot = 3'h6;
			32'h1000_0000: slot = 3'h7;
			default: slot = 3'h0;
		endcase
	end
	// counter runs free so refresh never depends on enables or sizes
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{counter_value, dev_ack, dev_rdata, wcnt, ensz_cnt} <= '0;
			{speed, ecc, scrub} <= '0;
			for (i = 0; i < 8; i = i + 1)
				{base[i], ensz[i]} <= '0;
		end
		else
		begin
			counter_value <= counter_value + 32'h1;
			dev_ack <= 1'b0;
			dev_rdata <= ~dev_rdata; // idle data bus never keeps a stale value
			if (dev_req && !dev_ack && wcnt < lat)
				wcnt <= wcnt + 4'h1;
			else if (dev_req && !dev_ack)
			begin
				wcnt <= 4'h0;
				dev_ack <= 1'b1;
				if (dev_mem && dev_write)
					mem[{blk, slot}] <= dev_wdata;
				else if (dev_mem)
					dev_rdata <= (real_code[blk] == 4'h0) ? ~mem[{blk, slot}] : mem[{blk, slot}];
				else if (dev_write && dev_addr == `DREG_SPEED)
					speed <= dev_wdata;
				else if (dev_write && dev_addr == `DREG_ECC)
					ecc <= dev_wdata;
				else if (dev_write && dev_addr == `DREG_SCRUB)
					scrub <= dev_wdata;
				else if (dev_write && dev_addr[31:3] == 29'h2)
					base[dev_addr[2:0]] <= dev_wdata;
				else if (dev_write && dev_addr[31:3] == 29'h3)
				begin
					ensz[dev_addr[2:0]] <= dev_wdata;
					ensz_cnt <= counter_value;
				end
			end
		end
	end
endmodule

// ### tb/sdram_block_sizing_config_test.sv
// self-checking bench: ahb software orders against the sdram block model
// assumes the sizer, the model and the checker are compiled alongside
`timescale 1ns/1ps
`include "sizer_consts.vh"
module sdram_block_sizing_config_test;
	reg clk_sys, arst_n, hsel, hwrite;
	reg [31:0] haddr, hwdata, d, junk;
	reg [1:0] htrans;
	reg [3:0] lat;
	wire hreadyout, hresp, dev_req, dev_write, dev_mem, dev_ack;
	wire [31:0] hrdata, dev_addr, counter_value;
	wire [63:0] dev_wdata, dev_rdata;
	integer err_total, checks, cyc, n;
	sdram_sizer sdram_sizer_inst (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .counter_value, .dev_req, .dev_write, .dev_mem,
		.dev_addr, .dev_wdata, .dev_rdata, .dev_ack);
	sdram_block_model sdram_block_model_inst (.clk_sys, .arst_n, .lat, .dev_req, .dev_write, .dev_mem,
		.dev_addr, .dev_wdata, .dev_rdata, .dev_ack, .counter_value);
	// ************
	// helpers
	// ************
	task complete_run;
	begin
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task chk(input string nm, input [63:0] e, input [63:0] g);
	begin
		checks = checks + 1;
		if (g !== e)
		begin
			$display("BAD %0s expected %h seen %h", nm, e, g);
			err_total = err_total + 1;
		end
	end
	endtask
	// one single transfer: address phase, then data phase, each held until hready
	task xfer(input w, input [31:0] a, input [31:0] wd, output [31:0] rd);
	begin
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		rd = hrdata;
		chk("hresp", 64'h0, {63'h0, hresp});
	end
	endtask
	task rd_chk(input [31:0] a, input [31:0] e, input string nm);
	begin
		xfer(1'b0, a, 32'h0, d);
		chk(nm, e, d);
	end
	endtask
	// start an order, then poll status until idle with done or error
	task run(input [31:0] cmd);
	begin
		xfer(1'b1, `OFS_CTRL, cmd, junk);
		xfer(1'b0, `OFS_STATUS, 32'h0, d);
		do
			xfer(1'b0, `OFS_STATUS, 32'h0, d);
		while (!(d[0] === 1'b0 && (d[1] | d[2]) === 1'b1));
	end
	endtask
	// clock and hang guard
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			err_total = err_total + 1;
			complete_run;
		end
	end
	// ************
	// main sequence
	// ************
	initial
	begin
		{arst_n, hsel, hwrite, haddr, hwdata, htrans, lat} = '0;
		{err_total, checks, cyc} = '0;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd_chk(`OFS_STATUS, 32'h0, "status reset");
		rd_chk(`OFS_SPEED, `SPEED_RESET, "speed reset");
		rd_chk(`OFS_CFG_LAST, `CFG_RESET, "cfg7 reset");
		xfer(1'b1, 32'h80, 32'hffff_ffff, junk);
		rd_chk(32'h80, 32'h0, "unmapped");
		// init: block 0 at base 0 code 9, block 1 at 512 mbyte code 5
		xfer(1'b1, `OFS_SPEED, 32'h0000_00a5, junk);
		rd_chk(`OFS_SPEED, 32'h0000_00a5, "speed rw");
		xfer(1'b1, `OFS_CFG0, 32'h0000_0019, junk);
		xfer(1'b1, `OFS_CFG0 + 4, 32'h0000_1015, junk);
		run(32'h1);
		chk("init status", 3'b010, d[2:0]);
		chk("speed dev", 64'h3a5, sdram_block_model_inst.speed);
		chk("base1 dev", 64'h2000_0000, sdram_block_model_inst.base[1]);
		chk("ensz1 dev", 64'h15, sdram_block_model_inst.ensz[1]);
		chk("ensz2 dev", 64'h0, sdram_block_model_inst.ensz[2]);
		chk("init settle", 1, counter_value - sdram_block_model_inst.ensz_cnt >= 100);
		// refused: misaligned base, enabled with no size, size code beyond 9
		for (n = 0; n < 3; n = n + 1)
		begin
			xfer(1'b1, `OFS_CFG0 + 4, (n == 0) ? 32'h215 : (n == 1) ? 32'h10 : 32'h1a, junk);
			run(32'h1);
			chk("refused", 2'b10, {d[2], d[0]});
			chk("base1 kept", 64'h2000_0000, sdram_block_model_inst.base[1]);
		end
		// pattern sizing against a slow device
		xfer(1'b1, `OFS_CFG0 + 4, 32'h0, junk);
		lat <= 4'h3;
		run(32'h2);
		chk("size status", 3'b010, d[2:0]);
		chk("ecc dev", 64'h4, sdram_block_model_inst.ecc);
		chk("scrub dev", 64'h0, sdram_block_model_inst.scrub);
		chk("size settle", 1, counter_value - sdram_block_model_inst.ensz_cnt >= 100);
		for (n = 0; n < 8; n = n + 1)
		begin
			xfer(1'b0, `OFS_CFG0 + 4 * n, 32'h0, d);
			chk("size code", sdram_block_model_inst.real_code[n], d[3:0]);
		end
		complete_run;
	end
endmodule
